// ===== wsm_defines.svh
// widths and tree geometry of the wide select multiplexer family
`ifndef WSM_DEFINES_SVH
`define WSM_DEFINES_SVH
`define WSM_MAX_SEL_W 5
`define WSM_MAX_DATA_W 32
`define WSM_LEVELS 5
`define WSM_NODES 31
`define WSM_DEC_SEL_W 4
`define WSM_DEC_OUT_W 16
`define WSM_EN_DATA_W 8
`endif

// ===== wsm_pkg.sv
// types shared by the wide select multiplexer family
`include "wsm_defines.svh"
package wsm_pkg;
  typedef logic [`WSM_MAX_DATA_W-1:0] wsm_data_t;
  typedef logic [`WSM_MAX_SEL_W-1:0] wsm_sel_t;
  typedef logic [`WSM_DEC_SEL_W-1:0] wsm_dec_sel_t;
  typedef logic [`WSM_DEC_OUT_W-1:0] wsm_onehot_t;
  typedef logic [`WSM_NODES-1:0] wsm_nodes_t;
endpackage

// ===== wsm_stage_if.sv
// signals of one 2:1 selection stage
`timescale 1ns/100ps
`default_nettype none
interface wsm_stage_if;
  logic first_data_in;
  logic second_data_in;
  logic sel;
  logic enable;
  logic cascade_out;
  logic general_out;
  modport stage (
    input first_data_in,
    input second_data_in,
    input sel,
    input enable,
    output cascade_out,
    output general_out
  );
  modport user (
    output first_data_in,
    output second_data_in,
    output sel,
    output enable,
    input cascade_out,
    input general_out
  );
endinterface
`default_nettype wire

// ===== wsm_stage.sv
// one 2:1 selection stage with local and general outputs
`timescale 1ns/100ps
`default_nettype none
module wsm_stage (
  wsm_stage_if.stage port_s
);
  logic picked;

  always_comb begin
    picked = 1'b0;
    case (port_s.sel)
      1'b0: begin
        picked = port_s.first_data_in;
      end
      1'b1: begin
        picked = port_s.second_data_in;
      end
      default: begin
        picked = 1'b0;
      end
    endcase
    if (!port_s.enable) begin
      picked = 1'b0;
    end
  end

  // both outputs come from the same gate, never a shared driven net
  assign port_s.cascade_out = picked;
  assign port_s.general_out = picked;
endmodule
`default_nettype wire

// ===== wsm_top.sv
// wide select multiplexer family: 2:1 to 32:1, enabled variants, decoder
// Summary of operation
// - select 0 passes first input, 1 second
// - cascade and general outputs always equal
// - wider selectors built from 2:1 stage tree
// - sizes 2:1 through 32:1, one-bit output
// - select is unsigned index of data bit
// - disabled selector drives output low
// - enable gated at first level for 4:1, 8:1
// - unknown select values get a defined output
// - select conditions exclusive, no priority chain
// - every output defaulted before conditional logic
// - plain gating only, no high-impedance drivers
// - decoder asserts one of sixteen outputs
`timescale 1ns/100ps
`default_nettype none
`include "wsm_defines.svh"
module wsm_top
  import wsm_pkg::*;
#(
  parameter int DEC_SEL_W = `WSM_DEC_SEL_W
) (
  input wire logic [`WSM_MAX_DATA_W-1:0] DATA_IN,
  input wire logic [`WSM_MAX_SEL_W-1:0] SEL,
  input wire logic ENABLE,
  input wire logic [`WSM_DEC_SEL_W-1:0] DEC_SEL,
  output logic OUT_2,
  output logic OUT_4,
  output logic OUT_8,
  output logic OUT_16,
  output logic OUT_32,
  output logic EN_OUT_4,
  output logic EN_OUT_8,
  output logic EN_OUT_16,
  output logic [`WSM_DEC_OUT_W-1:0] DEC_OUT
);

  // the decoder is a single table lookup, sized for at most four inputs
  if (DEC_SEL_W < 1 || DEC_SEL_W > `WSM_DEC_SEL_W) begin : g_bad_dec
    $error("decoder select width out of range");
  end

  // the flat node indexing assumes a full binary tree over the data bus
  if (`WSM_MAX_DATA_W != (1 << `WSM_LEVELS)) begin : g_bad_tree
    $error("data width is not two to the number of levels");
  end
  if (`WSM_NODES != `WSM_MAX_DATA_W - 1) begin : g_bad_nodes
    $error("node count does not match the data width");
  end
  if (`WSM_MAX_SEL_W != `WSM_LEVELS) begin : g_bad_sel
    $error("select width does not match the number of levels");
  end
  if (`WSM_DEC_OUT_W != (1 << `WSM_DEC_SEL_W)) begin : g_bad_dec_out
    $error("decoder output width is not two to its select width");
  end
  if (`WSM_EN_DATA_W != 8) begin : g_bad_en
    $error("enabled tree is built for three levels");
  end
  if (`WSM_MAX_DATA_W < 2 * `WSM_EN_DATA_W) begin : g_bad_en16
    $error("enabled 16:1 needs two eight-input subtrees");
  end

  // stage counts of the enabled 4:1 and 8:1 tree
  localparam int EN_LEAVES = `WSM_EN_DATA_W / 2;
  localparam int EN_MIDS = EN_LEAVES / 2;

  // first node index of a tree level in the flat node vectors
  function automatic int level_base(input int level);
    return `WSM_MAX_DATA_W - (`WSM_MAX_DATA_W >> level);
  endfunction

  // flat index of node n of a tree level
  function automatic int node_at(input int level, input int n);
    return level_base(level) + n;
  endfunction

  // one-hot code of a binary index
  function automatic wsm_onehot_t onehot(input wsm_dec_sel_t idx);
    wsm_onehot_t code;
    code = '0;
    // a full, flat table: every index has exactly one output high
    case (idx)
      4'h0: code = 16'h0001;
      4'h1: code = 16'h0002;
      4'h2: code = 16'h0004;
      4'h3: code = 16'h0008;
      4'h4: code = 16'h0010;
      4'h5: code = 16'h0020;
      4'h6: code = 16'h0040;
      4'h7: code = 16'h0080;
      4'h8: code = 16'h0100;
      4'h9: code = 16'h0200;
      4'ha: code = 16'h0400;
      4'hb: code = 16'h0800;
      4'hc: code = 16'h1000;
      4'hd: code = 16'h2000;
      4'he: code = 16'h4000;
      4'hf: code = 16'h8000;
      default: code = '0;
    endcase
    return code;
  endfunction

  wsm_nodes_t cascade_node;
  wsm_nodes_t general_node;
  // outputs of the enabled first, second and third level stages and of the enabled 16:1 final stage
  logic [EN_LEAVES-1:0] en_cascade;
  logic [EN_LEAVES-1:0] en_general;
  logic [EN_MIDS-1:0] en_mid_cascade;
  logic [EN_MIDS-1:0] en_mid_general;
  logic en_top_general;
  logic en16_general;
  wsm_dec_sel_t dec_idx;
  wsm_onehot_t dec_code;

  // plain tree: level 0 picks data pairs, each later level picks pairs
  // of the level below under the next select bit
  for (genvar lv = 0; lv < `WSM_LEVELS; lv++) begin : g_level
    for (genvar n = 0; n < (`WSM_MAX_DATA_W >> (lv + 1)); n++) begin : g_node
      wsm_stage_if sif ();
      wsm_stage u_stage (
        .port_s(sif)
      );
      if (lv == 0) begin : g_leaf
        assign sif.first_data_in = DATA_IN[2*n];
        assign sif.second_data_in = DATA_IN[2*n+1];
      end else begin : g_inner
        assign sif.first_data_in =
          cascade_node[node_at(lv - 1, 2*n)];
        assign sif.second_data_in =
          cascade_node[node_at(lv - 1, 2*n + 1)];
      end
      assign sif.sel = SEL[lv];
      assign sif.enable = 1'b1;
      assign cascade_node[node_at(lv, n)] = sif.cascade_out;
      assign general_node[node_at(lv, n)] = sif.general_out;
    end
  end

  // enabled 4:1 and 8:1: enable sits on the first-level stages only
  for (genvar n = 0; n < EN_LEAVES; n++) begin : g_en_leaf
    wsm_stage_if sif ();
    wsm_stage u_stage (
      .port_s(sif)
    );
    assign sif.first_data_in = DATA_IN[2*n];
    assign sif.second_data_in = DATA_IN[2*n+1];
    assign sif.sel = SEL[0];
    assign sif.enable = ENABLE;
    assign en_cascade[n] = sif.cascade_out;
    assign en_general[n] = sif.general_out;
  end

  // second level of the enabled tree, under SEL[1]
  for (genvar n = 0; n < EN_MIDS; n++) begin : g_en_mid
    wsm_stage_if sif ();
    wsm_stage u_stage (
      .port_s(sif)
    );
    assign sif.first_data_in = en_cascade[2*n];
    assign sif.second_data_in = en_cascade[2*n+1];
    assign sif.sel = SEL[1];
    assign sif.enable = 1'b1;
    assign en_mid_cascade[n] = sif.cascade_out;
    assign en_mid_general[n] = sif.general_out;
  end

  // final stage of the enabled 8:1, under SEL[2]
  wsm_stage_if en_top_if ();
  wsm_stage u_en_top (
    .port_s(en_top_if)
  );
  assign en_top_if.first_data_in = en_mid_cascade[0];
  assign en_top_if.second_data_in = en_mid_cascade[1];
  assign en_top_if.sel = SEL[2];
  assign en_top_if.enable = 1'b1;
  assign en_top_general = en_top_if.general_out;

  // enabled 16:1 keeps its enable on the final stage
  wsm_stage_if en16_if ();
  wsm_stage u_en16 (
    .port_s(en16_if)
  );
  assign en16_if.first_data_in = cascade_node[node_at(2, 0)];
  assign en16_if.second_data_in = cascade_node[node_at(2, 1)];
  assign en16_if.sel = SEL[3];
  assign en16_if.enable = ENABLE;
  assign en16_general = en16_if.general_out;

  // upper decoder bits are cleared when fewer than four are in use
  always_comb begin
    dec_idx = DEC_SEL;
    if (DEC_SEL_W < `WSM_DEC_SEL_W) begin
      dec_idx = DEC_SEL & wsm_dec_sel_t'((1 << DEC_SEL_W) - 1);
    end
  end

  always_comb begin
    dec_code = '0;
    dec_code = onehot(dec_idx);
  end

  // no storage anywhere: outputs follow inputs directly
  always_comb begin
    OUT_2 = general_node[level_base(0)];
    OUT_4 = general_node[level_base(1)];
    OUT_8 = general_node[level_base(2)];
    OUT_16 = general_node[level_base(3)];
    OUT_32 = general_node[level_base(4)];
  end

  // enabled outputs read the general outputs of their final stages
  always_comb begin
    EN_OUT_4 = en_mid_general[0];
    EN_OUT_8 = en_top_general;
    EN_OUT_16 = en16_general;
  end

  always_comb begin
    DEC_OUT = dec_code;
  end

endmodule
`default_nettype wire

// ===== wsm_top_assertions.sv
// concurrent checks on the ports of the multiplexer family
`timescale 1ns/100ps
`default_nettype none
module wsm_top_assertions #(
  parameter int DEC_SEL_W = 4
) (
  input wire logic [31:0] DATA_IN,
  input wire logic [4:0] SEL,
  input wire logic ENABLE,
  input wire logic [3:0] DEC_SEL,
  input wire logic OUT_2,
  input wire logic OUT_4,
  input wire logic OUT_8,
  input wire logic OUT_16,
  input wire logic OUT_32,
  input wire logic EN_OUT_4,
  input wire logic EN_OUT_8,
  input wire logic EN_OUT_16,
  input wire logic [15:0] DEC_OUT
);
  // own sampling clock, since the block has none
  logic smp_clk = 1'b0;
  logic [3:0] dmask;
  assign dmask = 4'((1 << DEC_SEL_W) - 1);
  always #50 smp_clk = ~smp_clk;
  default clocking @(posedge smp_clk); endclocking
  a_two_way: assert property (OUT_2 == DATA_IN[SEL[0]])
    else $error("bad 2:1");
  a_four_way: assert property (OUT_4 == DATA_IN[SEL[1:0]])
    else $error("bad 4:1");
  a_eight_way: assert property (OUT_8 == DATA_IN[SEL[2:0]])
    else $error("bad 8:1");
  a_sixteen_way: assert property (OUT_16 == DATA_IN[SEL[3:0]])
    else $error("bad 16:1");
  a_wide_index: assert property (OUT_32 == DATA_IN[SEL])
    else $error("bad 32:1");
  a_en_four: assert property (EN_OUT_4 == (ENABLE & DATA_IN[SEL[1:0]]))
    else $error("bad enabled 4:1");
  a_en_eight_on: assert property (ENABLE |->
    EN_OUT_8 == DATA_IN[SEL[2:0]])
    else $error("enabled 8:1 does not follow data");
  a_en_sixteen: assert property (
    EN_OUT_16 == (ENABLE & DATA_IN[SEL[3:0]]))
    else $error("bad enabled 16:1");
  a_en_eight: assert property (!ENABLE |-> !EN_OUT_8)
    else $error("bad enabled 8:1");
  a_dec_onehot: assert property (DEC_OUT == 16'h1 << (DEC_SEL & dmask))
    else $error("bad decoder");
  cover property (ENABLE && EN_OUT_16);
  cover property (SEL == 5'h1f && OUT_32);
  cover property (DEC_OUT[15]);
  cover property (!ENABLE && OUT_16);
endmodule
bind wsm_top wsm_top_assertions #(.DEC_SEL_W(DEC_SEL_W)) i_chk (.*);
`default_nettype wire

// ===== wsm_driver.sv
// surrounding logic that drives select, data, enable and decoder index
`timescale 1ns/100ps
`default_nettype none
module wsm_driver
  import wsm_pkg::*;
(
  input wire logic clk,
  output wsm_data_t data_in,
  output wsm_sel_t sel,
  output logic enable,
  output wsm_dec_sel_t dec_sel
);
  initial begin
    data_in = 32'h0;
    sel = 5'h0;
    enable = 1'b0;
    dec_sel = 4'h0;
  end
  // new values land on the falling edge only
  task automatic apply(input wsm_data_t d, input wsm_sel_t s,
                       input logic e, input wsm_dec_sel_t ds);
    @(negedge clk);
    data_in = d;
    sel = s;
    enable = e;
    dec_sel = ds;
  endtask
endmodule
`default_nettype wire

// ===== wide_select_multiplexer_bench.sv
// self-checking bench of the multiplexer family
`timescale 1ns/100ps
`default_nettype none
module wide_select_multiplexer_bench;
  import wsm_pkg::*;
  logic clk;
  wsm_data_t data_in;
  wsm_sel_t sel;
  logic enable;
  wsm_dec_sel_t dec_sel;
  logic o2, o4, o8, o16, o32, e4, e8, e16;
  wsm_onehot_t dec_out;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  wsm_driver i_wsm_driver (.clk(clk), .data_in(data_in), .sel(sel),
    .enable(enable), .dec_sel(dec_sel));
  wsm_top i_wsm_top (.DATA_IN(data_in), .SEL(sel), .ENABLE(enable),
    .DEC_SEL(dec_sel), .OUT_2(o2), .OUT_4(o4), .OUT_8(o8), .OUT_16(o16),
    .OUT_32(o32), .EN_OUT_4(e4), .EN_OUT_8(e8), .EN_OUT_16(e16),
    .DEC_OUT(dec_out));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // walking one and walking zero under every select value
  task automatic t_index();
    wsm_data_t d;
    for (int s = 0; s < 32; s++) begin
      d = 32'h1 << s;
      for (int k = 0; k < 2; k++) begin
        i_wsm_driver.apply(d, s[4:0], 1'b1, 4'h0);
        #10;
        chk(o2, d[s[0]]);
        chk(o4, d[s[1:0]]);
        chk(o8, d[s[2:0]]);
        chk(o16, d[s[3:0]]);
        chk(o32, d[s]);
        d = ~d;
      end
    end
    $display("test index done");
  endtask
  // select 0x0b reads bit 3 for 4:1 and 8:1, bit 11 for 16:1
  task automatic t_enable();
    wsm_data_t d;
    for (int k = 0; k < 4; k++) begin
      d = k[1] ? 32'h0000_0800 : 32'hffff_f7ff;
      i_wsm_driver.apply(d, 5'h0b, k[0], 4'h0);
      #10;
      chk(e4, k[0] & d[3]);
      chk(e8, k[0] & d[3]);
      chk(e16, k[0] & d[11]);
    end
    $display("test enable done");
  endtask
  task automatic t_decode();
    for (int v = 0; v < 16; v++) begin
      i_wsm_driver.apply(32'h0, 5'h0, 1'b0, v[3:0]);
      #10;
      chk(dec_out, 32'h1 << v);
    end
    $display("test decode done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    t_index();
    t_enable();
    t_decode();
    print_verdict();
  end
endmodule
`default_nettype wire
